/* File: design/adc_top.sv */
// Purpose: extended-mode audio transfer counter, request and control registers
// Assumes: host port decoded to a 4-bit offset
// Notes:   pin inputs pass three flops
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - reload low byte resets to zero
// - reload high byte resets to F8
// - counter loads at start and overflow
// - count up per DMA byte, overflow past FFFF
// - auto-init keeps requesting, overflow only interrupts
// - normal mode stops requests on overflow
// - overflow interrupt when enable bit set
// - half-empty change interrupts during block I/O
// - interrupt control bit 4 ignored, activate enables
// - irq control low nibble reports irq
// - ext enable selects DMA, else block I/O
// - request driven; low without any enable
// - dma control low nibble reports channel
// - mic gain bit, set by reset
// - rate trim bit, cleared by reset
// - outputs muted 100 ms after reset/wake
// - FM level field, reset 0 dB code
// - compat: ack low releases request
// - ext: ack and matching strobe release
module adc_top #(
  parameter int MUTE_CYCLES = adc_pkg::MUTE_CYCLES,
  parameter int FIFO_DEPTH  = 4
) (
  input  wire logic       sys_clk_in,        // 10 MHz clock
  input  wire logic       rst_b_in,          // sync reset, low
  input  wire logic [3:0] port_addr_in,      // offset in base window
  input  wire logic       io_read_strobe_n_in,  // host read strobe, low
  input  wire logic       io_write_strobe_n_in, // host write strobe, low
  input  wire logic [7:0] host_data_in,      // host write data
  output logic      [7:0] host_data_out,     // host read data
  output logic            host_data_oe_out,  // data bus drive enable
  input  wire logic       dma_ack_n_in,      // dma acknowledge, low
  output logic            dma_request_line_out, // dma request
  output logic            irq_out,           // interrupt request
  input  wire logic       activate_in,       // logical device active
  input  wire logic [1:0] irq_sel_in,        // chosen irq, 0 = other
  input  wire logic [1:0] dma_sel_in,        // chosen channel, 0 = other
  input  wire logic       auto_init_in,      // auto-initialize mode
  input  wire logic       dma_read_in,       // 1: host reads from device
  input  wire logic       start_in,          // new transfer command pulse
  input  wire logic       wake_in,           // analog wake-up pulse
  input  wire logic       src_valid_in,      // playback byte offered
  output logic            src_ready_out,     // fifo has room
  input  wire logic [7:0] src_data_in,       // playback byte
  input  wire logic       sink_ready_in,     // consumer takes a byte
  output logic            sink_valid_out,    // byte for consumer
  output logic      [7:0] sink_data_out,     // byte for consumer
  output logic            mic_gain_out,      // 1: +26 dB preamp
  output logic            sample_rate_trim_out, // clock trim enable
  output logic            fm_level_hi_out,   // fm level bit 1
  output logic            fm_level_lo_out,   // fm level bit 0
  output logic            mute_out           // analog outputs muted
);
  localparam int MW = $clog2(MUTE_CYCLES + 1);

  // registers
  logic [7:0]  reload_low;
  logic [7:0]  reload_high;
  logic [7:0]  mic_preamp;
  logic [7:0]  irq_ctrl;
  logic [7:0]  dma_ctrl;
  logic [7:0]  rate_wake;
  logic [7:0]  fm_level;
  logic [7:0]  index_reg;
  logic [15:0] xfer_count;
  logic        running;
  logic        loaded;
  logic [MW-1:0] mute_cnt;

  // synchronisers: s1 feeds s2 only; s2/s3 agree -> stable
  logic [2:0] rd_s;
  logic [2:0] wr_s;
  logic [2:0] ack_s;
  logic       rd_n;
  logic       wr_n;
  logic       ack_n;
  logic       rd_q;
  logic       wr_q;
  logic       ack_q;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      rd_s  <= 3'b111;
      wr_s  <= 3'b111;
      ack_s <= 3'b111;
    end else begin
      rd_s  <= {rd_s[1:0], io_read_strobe_n_in};
      wr_s  <= {wr_s[1:0], io_write_strobe_n_in};
      ack_s <= {ack_s[1:0], dma_ack_n_in};
    end
  end

  // a level changes once stages two and three agree
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      rd_n  <= 1'b1;
      wr_n  <= 1'b1;
      ack_n <= 1'b1;
      rd_q  <= 1'b1;
      wr_q  <= 1'b1;
      ack_q <= 1'b1;
    end else begin
      if (rd_s[1] == rd_s[2]) rd_n <= rd_s[2];
      if (wr_s[1] == wr_s[2]) wr_n <= wr_s[2];
      if (ack_s[1] == ack_s[2]) ack_n <= ack_s[2];
      rd_q  <= rd_n;
      wr_q  <= wr_n;
      ack_q <= ack_n;
    end
  end

  // strobe edges; host i/o only counts when ack is high
  logic io_rd_fall;
  logic io_wr_rise;
  logic io_wr_fall;
  logic io_rd_rise;
  logic dma_byte;
  logic ext_en;
  logic comp_en;
  logic fifo_half;
  logic half_q;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_ready;
  assign io_rd_fall = rd_q && !rd_n;
  assign io_rd_rise = !rd_q && rd_n;
  assign io_wr_fall = wr_q && !wr_n;
  assign io_wr_rise = !wr_q && wr_n;
  assign ext_en     = dma_ctrl[adc_pkg::BIT_DRQ_EXT];
  assign comp_en    = dma_ctrl[adc_pkg::BIT_DRQ_COMP];
  // one byte moved per completed strobe under ack
  assign dma_byte   = !ack_n && (dma_read_in ? io_rd_rise : io_wr_rise);

  // index then data port writes
  logic reg_wr;
  logic idx_wr;
  assign idx_wr = ack_n && io_wr_fall && port_addr_in == adc_pkg::PORT_INDEX;
  assign reg_wr = ack_n && io_wr_fall && port_addr_in == adc_pkg::PORT_DATA;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      index_reg <= 8'h00;
    end else if (idx_wr) begin
      index_reg <= host_data_in;
    end
  end

  // register file; read-only nibbles not stored
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      reload_low  <= adc_pkg::RST_RELOAD_LOW;
      reload_high <= adc_pkg::RST_RELOAD_HIGH;
      mic_preamp  <= adc_pkg::RST_MIC_PREAMP;
      irq_ctrl    <= adc_pkg::RST_IRQ_CTRL;
      dma_ctrl    <= adc_pkg::RST_DMA_CTRL;
      rate_wake   <= adc_pkg::RST_RATE_WAKE;
      fm_level    <= adc_pkg::RST_FM_LEVEL;
    end else if (reg_wr) begin
      unique case (index_reg)
        adc_pkg::IDX_RELOAD_LOW:  reload_low  <= host_data_in;
        adc_pkg::IDX_RELOAD_HIGH: reload_high <= host_data_in;
        adc_pkg::IDX_MIC_PREAMP:  mic_preamp  <= host_data_in;
        adc_pkg::IDX_IRQ_CTRL:    irq_ctrl    <= host_data_in & adc_pkg::MASK_CTRL_RW;
        adc_pkg::IDX_DMA_CTRL:    dma_ctrl    <= host_data_in & adc_pkg::MASK_CTRL_RW;
        adc_pkg::IDX_RATE_WAKE:   rate_wake   <= host_data_in & adc_pkg::MASK_RATE_RW;
        adc_pkg::IDX_FM_LEVEL:    fm_level    <= host_data_in;
        default: ;
      endcase
    end
  end

  // read-only channel codes
  function automatic logic [3:0] sel_code(input logic [1:0] s);
    case (s)
      adc_pkg::SEL_A: sel_code = adc_pkg::CODE_A;
      adc_pkg::SEL_B: sel_code = adc_pkg::CODE_B;
      adc_pkg::SEL_C: sel_code = adc_pkg::CODE_C;
      default:        sel_code = adc_pkg::CODE_NONE;
    endcase
  endfunction

  // read mux; unmapped indices read zero
  logic [7:0] rd_val;
  always_comb begin
    rd_val = 8'h00;
    if (port_addr_in == adc_pkg::PORT_INDEX) begin
      rd_val = index_reg;
    end else if (port_addr_in == adc_pkg::PORT_DATA) begin
      case (index_reg)
        adc_pkg::IDX_RELOAD_LOW:  rd_val = reload_low;
        adc_pkg::IDX_RELOAD_HIGH: rd_val = reload_high;
        adc_pkg::IDX_MIC_PREAMP:  rd_val = mic_preamp;
        adc_pkg::IDX_IRQ_CTRL:    rd_val = {irq_ctrl[7:4], sel_code(irq_sel_in)};
        adc_pkg::IDX_DMA_CTRL:    rd_val = {dma_ctrl[7:4], sel_code(dma_sel_in)};
        adc_pkg::IDX_RATE_WAKE:   rd_val = rate_wake;
        adc_pkg::IDX_FM_LEVEL:    rd_val = fm_level;
        default:                  rd_val = 8'h00;
      endcase
    end
  end

  // read data latched at strobe fall, driven until strobe rises
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      host_data_out    <= 8'h00;
      host_data_oe_out <= 1'b0;
    end else if (ack_n && io_rd_fall) begin
      host_data_out    <= rd_val;
      host_data_oe_out <= 1'b1;
    end else if (!ack_n && dma_read_in && io_rd_fall) begin
      host_data_out    <= sink_data_out;
      host_data_oe_out <= 1'b1;
    end else if (rd_n) begin
      host_data_oe_out <= 1'b0;
    end
  end

  // transfer counter; start and overflow load it
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      xfer_count <= 16'h0000;
      loaded     <= 1'b0;
    end else if (start_in) begin
      xfer_count <= {reload_high, reload_low};
      loaded     <= 1'b1;
    end else if (dma_byte && running) begin
      if (xfer_count == adc_pkg::CNT_MAX) begin
        xfer_count <= {reload_high, reload_low};
      end else begin
        xfer_count <= xfer_count + adc_pkg::CNT_ONE;
      end
    end
  end

  logic overflow;
  assign overflow = dma_byte && running && xfer_count == adc_pkg::CNT_MAX;

  // normal mode halts on overflow until start
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      running <= 1'b0;
    end else if (start_in) begin
      running <= 1'b1;
    end else if (overflow && !auto_init_in) begin
      running <= 1'b0;
    end
  end

  // request release: ack (compat) or ack and strobe (ext)
  logic release_req;
  logic want_req;
  assign release_req = comp_en && !ext_en ? !ack_n
                     : !ack_n && (dma_read_in ? !rd_n : !wr_n);
  // fifo back-pressure stalls requests
  assign want_req    = running && loaded && (ext_en || comp_en) &&
                       (dma_read_in ? sink_valid_out : fifo_in_ready);
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      dma_request_line_out <= 1'b0;
    end else if (!ext_en && !comp_en) begin
      dma_request_line_out <= 1'b0;
    end else if (release_req || (overflow && !auto_init_in)) begin
      dma_request_line_out <= 1'b0;
    end else begin
      dma_request_line_out <= want_req && ack_n;
    end
  end

  // fifo fill: source bytes on dma reads, else dma writes or block i/o
  logic [7:0] fifo_din;
  logic       blk_wr;
  assign blk_wr         = !ext_en && ack_n && io_wr_fall && port_addr_in == adc_pkg::PORT_INDEX;
  assign fifo_in_valid  = dma_read_in ? src_valid_in
                        : ((ext_en && !ack_n && io_wr_fall) || blk_wr);
  assign fifo_din       = dma_read_in ? src_data_in : host_data_in;
  assign src_ready_out  = dma_read_in && fifo_in_ready;
  assign fifo_out_ready = dma_read_in ? dma_byte : sink_ready_in;

  adc_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_in     (sys_clk_in),
    .rst_b_in       (rst_b_in),
    .in_valid_in    (fifo_in_valid),
    .in_ready_out   (fifo_in_ready),
    .in_data_in     (fifo_din),
    .out_valid_out  (sink_valid_out),
    .out_ready_in   (fifo_out_ready),
    .out_data_out   (sink_data_out),
    .half_empty_out (fifo_half)
  );

  // interrupt: bit 4 ignored, pin gated by activate
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      half_q  <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      half_q <= fifo_half;
      if ((overflow && irq_ctrl[adc_pkg::BIT_IRQ_OVF]) ||
          (!ext_en && half_q != fifo_half && irq_ctrl[adc_pkg::BIT_IRQ_HALF])) begin
        irq_out <= activate_in;
      end else if (start_in || !activate_in) begin
        irq_out <= 1'b0;
      end
    end
  end

  // mute timer restarts on reset or wake unless disabled
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      mute_cnt <= MW'(MUTE_CYCLES);
      mute_out <= 1'b1;
    end else if (wake_in) begin
      mute_cnt <= MW'(MUTE_CYCLES);
      mute_out <= !rate_wake[adc_pkg::BIT_DELAY_OFF];
    end else begin
      if (mute_cnt != '0) mute_cnt <= mute_cnt - MW'(1);
      mute_out <= mute_cnt > MW'(1) && !rate_wake[adc_pkg::BIT_DELAY_OFF];
    end
  end

  // simple control outputs
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      mic_gain_out         <= adc_pkg::RST_MIC_PREAMP[adc_pkg::BIT_MIC_GAIN];
      sample_rate_trim_out <= 1'b0;
      fm_level_hi_out      <= adc_pkg::RST_FM_LEVEL[adc_pkg::BIT_FM_HI];
      fm_level_lo_out      <= adc_pkg::RST_FM_LEVEL[adc_pkg::BIT_FM_LO];
    end else begin
      mic_gain_out         <= mic_preamp[adc_pkg::BIT_MIC_GAIN];
      sample_rate_trim_out <= rate_wake[adc_pkg::BIT_RATE_TRIM];
      fm_level_hi_out      <= fm_level[adc_pkg::BIT_FM_HI];
      fm_level_lo_out      <= fm_level[adc_pkg::BIT_FM_LO];
    end
  end
endmodule
`default_nettype wire

/* File: design/adc_pkg.sv */
// Purpose: shared constants for the audio dma counter control block
// Assumes: 8-bit indirect register port, 10 MHz system clock
// Notes:   indices are extension register numbers
package adc_pkg;
  // register indices
  localparam logic [7:0] IDX_RELOAD_LOW  = 8'hA4;
  localparam logic [7:0] IDX_RELOAD_HIGH = 8'hA5;
  localparam logic [7:0] IDX_MIC_PREAMP  = 8'hA9;
  localparam logic [7:0] IDX_IRQ_CTRL    = 8'hB1;
  localparam logic [7:0] IDX_DMA_CTRL    = 8'hB2;
  localparam logic [7:0] IDX_RATE_WAKE   = 8'hBA;
  localparam logic [7:0] IDX_FM_LEVEL    = 8'hBC;
  // host port offsets
  localparam logic [3:0] PORT_INDEX = 4'hC;
  localparam logic [3:0] PORT_DATA  = 4'hE;
  // reset values
  localparam logic [7:0] RST_RELOAD_LOW  = 8'h00;
  localparam logic [7:0] RST_RELOAD_HIGH = 8'hF8;
  localparam logic [7:0] RST_MIC_PREAMP  = 8'h04;
  localparam logic [7:0] RST_IRQ_CTRL    = 8'h00;
  localparam logic [7:0] RST_DMA_CTRL    = 8'h00;
  localparam logic [7:0] RST_RATE_WAKE   = 8'h00;
  localparam logic [7:0] RST_FM_LEVEL    = 8'hB6;
  // field positions
  localparam int BIT_MIC_GAIN    = 2;
  localparam int BIT_IRQ_OVF     = 6;
  localparam int BIT_IRQ_HALF    = 5;
  localparam int BIT_DRQ_EXT     = 6;
  localparam int BIT_DRQ_COMP    = 5;
  localparam int BIT_RATE_TRIM   = 6;
  localparam int BIT_DELAY_OFF   = 5;
  localparam int BIT_FM_HI       = 7;
  localparam int BIT_FM_LO       = 6;
  // writable masks; control low nibbles read-only
  localparam logic [7:0] MASK_CTRL_RW = 8'hF0;
  localparam logic [7:0] MASK_RATE_RW = 8'h7F;
  // channel select codes
  localparam logic [3:0] CODE_NONE = 4'h0;
  localparam logic [3:0] CODE_A    = 4'h5;
  localparam logic [3:0] CODE_B    = 4'hA;
  localparam logic [3:0] CODE_C    = 4'hF;
  localparam logic [1:0] SEL_A     = 2'h1;
  localparam logic [1:0] SEL_B     = 2'h2;
  localparam logic [1:0] SEL_C     = 2'h3;
  // timing
  localparam int CLK_HZ        = 10_000_000;
  localparam int MUTE_MS       = 100;
  localparam int MUTE_CYCLES   = (CLK_HZ / 1000) * MUTE_MS;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
endpackage

/* File: design/adc_fifo.sv */
// Purpose: small data fifo on the dma byte path
// Assumes: single clock, synchronous active-low reset
// Notes:   full and empty are exact; no bypass path
`timescale 1ns/1ns
`default_nettype none
module adc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             sys_clk_in,  // system clock
  input  wire logic             rst_b_in,    // sync reset, low
  input  wire logic             in_valid_in, // write request
  output logic                  in_ready_out,// room available
  input  wire logic [WIDTH-1:0] in_data_in,  // write data
  output logic                  out_valid_out,// data available
  input  wire logic             out_ready_in,// drain request
  output logic [WIDTH-1:0]      out_data_out,// head word
  output logic                  half_empty_out // at most half full
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             do_wr;
  logic             do_rd;

  // handshakes
  assign do_wr          = in_valid_in && in_ready_out;
  assign do_rd          = out_valid_out && out_ready_in;
  assign in_ready_out   = (count != (AW+1)'(DEPTH));
  assign out_valid_out  = (count != '0);
  assign out_data_out   = mem[rd_ptr];
  assign half_empty_out = (count <= (AW+1)'(DEPTH / 2));

  // storage has no reset; only pointers matter
  always_ff @(posedge sys_clk_in) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  // pointers and fill count
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
      end
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule
`default_nettype wire

/* File: test/adc_chk_sva.sv */
// Purpose: port-level checks for adc_top
// Assumes: one clock, synchronous active-low reset
// Notes:   mute window checked until the first wake
`timescale 1ns/1ns
`default_nettype none
module adc_chk #(
  parameter int MUTE_CYCLES = 20
) (
  input wire logic sys_clk_in,           // clock
  input wire logic rst_b_in,             // reset, low
  input wire logic io_read_strobe_n_in,  // read strobe
  input wire logic io_write_strobe_n_in, // write strobe
  input wire logic dma_ack_n_in,         // ack
  input wire logic dma_read_in,          // direction
  input wire logic auto_init_in,         // auto mode
  input wire logic activate_in,          // active
  input wire logic start_in,             // start pulse
  input wire logic wake_in,              // wake pulse
  input wire logic dma_request_line_out, // request
  input wire logic irq_out,              // interrupt
  input wire logic host_data_oe_out,     // bus drive
  input wire logic mute_out,             // mute
  input wire logic mic_gain_out,         // gain
  input wire logic sample_rate_trim_out, // trim
  input wire logic fm_level_hi_out,      // fm bit 1
  input wire logic fm_level_lo_out       // fm bit 0
);
  int unsigned since_rst; // saturating cycle count
  logic        woke;      // wake seen
  default clocking dc @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  // count stops at window end; after a wake mute hangs on a hidden bit
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      since_rst <= 0;
      woke      <= 1'b0;
    end else begin
      if (since_rst < MUTE_CYCLES) since_rst <= since_rst + 1;
      if (wake_in) woke <= 1'b1;
    end
  end
  a_ext_release: assert property (
    (!dma_ack_n_in && !io_write_strobe_n_in && !dma_read_in) [*7] |-> !dma_request_line_out)
    else $error("request not released");
  a_irq_clear: assert property (
    start_in || !activate_in |-> ##[1:2] !irq_out)
    else $error("interrupt not cleared");
  a_irq_hold: assert property (
    irq_out && activate_in && !start_in |=> irq_out)
    else $error("interrupt dropped");
  a_oe_idle: assert property (
    io_read_strobe_n_in [*8] |-> !host_data_oe_out)
    else $error("bus driven idle");
  a_rst_quiet: assert property (
    $rose(rst_b_in) |-> !dma_request_line_out && !irq_out && !host_data_oe_out)
    else $error("outputs active after reset");
  a_rst_config: assert property (
    $rose(rst_b_in) |-> mic_gain_out && fm_level_hi_out && !fm_level_lo_out
      && !sample_rate_trim_out && mute_out)
    else $error("controls wrong after reset");
  a_mute_hold: assert property (
    !woke && since_rst < MUTE_CYCLES * 4 / 5 |-> mute_out)
    else $error("mute ended early");
  a_req_stop: assert property (
    $rose(irq_out) && !auto_init_in && !start_in |-> !dma_request_line_out [*3])
    else $error("request after overflow");
endmodule
bind adc_top adc_chk #(.MUTE_CYCLES(MUTE_CYCLES)) i_adc_chk (.*);
`default_nettype wire

/* File: test/adc_host_model.sv */
// Purpose: host bus and system dma controller stand-in
// Assumes: tasks are entered just after a clock edge
// Notes:   released write data shows the inverse of the last byte
`timescale 1ns/1ns
`default_nettype none
module adc_host_model (
  input  wire logic       sys_clk_in, // bench clock
  input  wire logic [7:0] rdata_in,   // device read data
  input  wire logic       req_in,     // device request
  output logic      [3:0] addr_out,   // port offset
  output logic            rd_n_out,   // read strobe, low
  output logic            wr_n_out,   // write strobe, low
  output logic      [7:0] wdata_out,  // write data
  output logic            ack_n_out   // acknowledge, low
);
  // idle bus at time zero
  initial begin
    addr_out = 4'h0;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    wdata_out = 8'h00;
    ack_n_out = 1'b1;
  end
  // seven edges let the three-flop input see the strobe
  task automatic port_cycle(input logic rd, input logic [3:0] a, input logic [7:0] d,
                            output logic [7:0] q);
    @(posedge sys_clk_in);
    addr_out <= a;
    wdata_out <= d;
    rd_n_out <= !rd;
    wr_n_out <= rd;
    repeat (7) @(posedge sys_clk_in);
    q = rdata_in;
    rd_n_out <= 1'b1;
    wr_n_out <= 1'b1;
    wdata_out <= ~d;
    repeat (5) @(posedge sys_clk_in);
  endtask
  // index to port C, data via port E
  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    port_cycle(1'b0, adc_pkg::PORT_INDEX, idx, q);
    port_cycle(1'b0, adc_pkg::PORT_DATA, d, q);
  endtask
  task automatic reg_rd(input logic [7:0] idx, output logic [7:0] q);
    port_cycle(1'b0, adc_pkg::PORT_INDEX, idx, q);
    port_cycle(1'b1, adc_pkg::PORT_DATA, ~idx, q);
  endtask
  // one byte; lag delays ack, no strobe in compat
  task automatic dma_byte(input logic with_cmd, input int lag, input logic [7:0] d,
                          output logic ok);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    while (!req_in && n < 40) begin
      @(posedge sys_clk_in);
      n++;
    end
    ok = req_in;
    if (ok) begin
      repeat (lag) @(posedge sys_clk_in);
      ack_n_out <= 1'b0;
      wr_n_out <= !with_cmd;
      wdata_out <= d;
      n = 0;
      while (req_in && n < 20) begin
        @(posedge sys_clk_in);
        n++;
      end
      ok = !req_in;
      wr_n_out <= 1'b1;
      repeat (2) @(posedge sys_clk_in);
      ack_n_out <= 1'b1;
      wdata_out <= ~d;
      repeat (6) @(posedge sys_clk_in);
    end
  endtask
endmodule
`default_nettype wire

/* File: test/test_audio_dma_counter_ctrl.sv */
// Purpose: self-checking bench for adc_top
// Assumes: host model drives pins and acknowledge
// Notes:   mute window cut to 20 cycles
`timescale 1ns/1ns
`default_nettype none
module test_audio_dma_counter_ctrl;
  typedef struct packed {
    logic [7:0] idx;
    logic       wen;
    logic [7:0] wd;
    logic [7:0] want;
  } adc_row_t;
  logic       sys_clk_in = 1'b0;
  logic       rst_b_in, rd_n, wr_n, ack_n, req, irq, activate, auto_init, start, wake;
  logic       sink_ready, sink_valid, mic, trim, fm_hi, fm_lo, mute, ok;
  logic [1:0] irq_sel, dma_sel;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, sink_data, q;
  int         bad_count, check_count, cycles;
  logic [3:0] codes [4] = '{4'h0, 4'h5, 4'hA, 4'hF};
  adc_row_t   rows [15] = '{
    '{8'hA4,1'b0,8'h00,8'h00},
    '{8'hA5,1'b0,8'h00,8'hF8},
    '{8'hA9,1'b0,8'h00,8'h04},
    '{8'hB1,1'b0,8'h00,8'h05},
    '{8'hB2,1'b0,8'h00,8'h0F},
    '{8'hBA,1'b0,8'h00,8'h00},
    '{8'hBC,1'b0,8'h00,8'hB6},
    '{8'hA4,1'b1,8'hFE,8'hFE},
    '{8'hA5,1'b1,8'hFF,8'hFF},
    '{8'hB1,1'b1,8'h1A,8'h15},
    '{8'hB2,1'b1,8'h4A,8'h4F},
    '{8'hBA,1'b1,8'hE0,8'h60},
    '{8'hBC,1'b1,8'h76,8'h76},
    '{8'hA9,1'b1,8'h00,8'h00},
    '{8'hA0,1'b1,8'h5A,8'h00}
  };
  adc_top #(.MUTE_CYCLES(20), .FIFO_DEPTH(4)) i_adc_top (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .port_addr_in(addr),
    .io_read_strobe_n_in(rd_n), .io_write_strobe_n_in(wr_n), .host_data_in(wdata),
    .host_data_out(rdata), .host_data_oe_out(), .dma_ack_n_in(ack_n),
    .dma_request_line_out(req), .irq_out(irq), .activate_in(activate),
    .irq_sel_in(irq_sel), .dma_sel_in(dma_sel), .auto_init_in(auto_init),
    .dma_read_in(1'b0), .start_in(start), .wake_in(wake), .src_valid_in(1'b0),
    .src_ready_out(), .src_data_in(8'h00), .sink_ready_in(sink_ready),
    .sink_valid_out(sink_valid), .sink_data_out(sink_data), .mic_gain_out(mic),
    .sample_rate_trim_out(trim), .fm_level_hi_out(fm_hi), .fm_level_lo_out(fm_lo),
    .mute_out(mute)
  );
  adc_host_model i_adc_host_model (
    .sys_clk_in(sys_clk_in), .rdata_in(rdata), .req_in(req), .addr_out(addr),
    .rd_n_out(rd_n), .wr_n_out(wr_n), .wdata_out(wdata), .ack_n_out(ack_n)
  );
  // clock and hang guard
  always #50 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic check(input string what, input logic [7:0] want, input logic [7:0] got);
    check_count++;
    if (got !== want) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, want, got);
    end
  endtask
  // register access through the host model
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    i_adc_host_model.reg_wr(i, d);
  endtask
  task automatic rd(input logic [7:0] i);
    i_adc_host_model.reg_rd(i, q);
  endtask
  // one-cycle command pulse
  task automatic pulse(input logic is_wake);
    if (is_wake) wake <= 1'b1;
    else start <= 1'b1;
    @(posedge sys_clk_in);
    wake <= 1'b0;
    start <= 1'b0;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    rst_b_in = 1'b0;
    activate = 1'b0;
    auto_init = 1'b0;
    start = 1'b0;
    wake = 1'b0;
    sink_ready = 1'b1;
    irq_sel = 2'h1;
    dma_sel = 2'h3;
    repeat (4) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    // register rows: resets, writes, read-only nibbles, unmapped
    foreach (rows[i]) begin
      if (rows[i].wen) wr(rows[i].idx, rows[i].wd);
      rd(rows[i].idx);
      check("register", rows[i].want, q);
    end
    check("gain", 8'h00, 8'(mic));
    check("trim", 8'h01, 8'(trim));
    // all fm level and channel codes
    for (int c = 0; c < 4; c++) begin
      wr(8'hBC, {c[1:0], 6'h36});
      irq_sel <= c[1:0];
      dma_sel <= c[1:0];
      check("fm level", 8'(c), {6'h00, fm_hi, fm_lo});
      rd(8'hB1);
      check("irq code", {4'h1, codes[c]}, q);
      rd(8'hB2);
      check("dma code", {4'h4, codes[c]}, q);
    end
    // wake mutes only with the delay enabled
    pulse(1'b1);
    repeat (3) @(posedge sys_clk_in);
    check("mute disabled", 8'h00, 8'(mute));
    wr(8'hBA, 8'h40);
    pulse(1'b1);
    repeat (3) @(posedge sys_clk_in);
    check("mute on wake", 8'h01, 8'(mute));
    repeat (30) @(posedge sys_clk_in);
    check("mute end", 8'h00, 8'(mute));
    // normal mode: FFFE overflows on byte two, then halts
    wr(8'hB1, 8'h40);
    wr(8'hB2, 8'h40);
    activate <= 1'b1;
    pulse(1'b0);
    for (int i = 0; i < 2; i++) begin
      i_adc_host_model.dma_byte(1'b1, i * 3, 8'h20, ok);
      check("ext release", 8'h01, 8'(ok));
    end
    repeat (10) @(posedge sys_clk_in);
    check("overflow irq", 8'h01, 8'(irq));
    check("halted request", 8'h00, 8'(req));
    // auto mode: requests go on past overflow
    auto_init <= 1'b1;
    pulse(1'b0);
    for (int i = 0; i < 4; i++) begin
      i_adc_host_model.dma_byte(1'b1, 0, 8'h30, ok);
      check("auto byte", 8'h01, 8'(ok));
      repeat (4) @(posedge sys_clk_in);
      check("auto irq", 8'(i % 2), 8'(irq));
      activate <= 1'b0;
      @(posedge sys_clk_in);
      activate <= 1'b1;
    end
    // compat: ack alone releases; no enable, no request
    wr(8'hB2, 8'h20);
    pulse(1'b0);
    i_adc_host_model.dma_byte(1'b0, 3, 8'h40, ok);
    check("compat release", 8'h01, 8'(ok));
    wr(8'hB2, 8'h00);
    pulse(1'b0);
    repeat (20) @(posedge sys_clk_in);
    check("no enable", 8'h00, 8'(req));
    // stalled drain: four bytes fill the fifo, no fifth request
    wr(8'hB2, 8'h40);
    sink_ready <= 1'b0;
    pulse(1'b0);
    for (int i = 0; i < 5; i++) begin
      i_adc_host_model.dma_byte(1'b1, 0, 8'h50 + 8'(i), ok);
      check("fifo accept", 8'(i < 4), 8'(ok));
    end
    check("fifo head", 8'h50, sink_data);
    sink_ready <= 1'b1;
    repeat (8) @(posedge sys_clk_in);
    check("fifo empty", 8'h00, 8'(sink_valid));
    // second reset restores the reload value
    rst_b_in <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    rd(8'hA5);
    check("reload again", 8'hF8, q);
    conclude();
  end
endmodule
`default_nettype wire
